//--- pic_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "pic_cfg.svh"
module pic_controller #(
  parameter logic [11:0] NMI_CODE  = 12'h1c0,
  parameter logic [11:0] IRQ_CODE0 = 12'h200,
  parameter logic [11:0] PER_CODE0 = 12'h400
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  // avalon-mm register slave
  input  wire logic [31:0]  avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  // request sources
  input  wire logic         nmiPin,
  input  wire logic [7:0]   irqPin,
  input  wire logic [2:0]   perReq,
  // link to the core
  pic_core_if.ctrl          core
);
  localparam int NSRC = 11;

  pic_pkg::pic_bus_e busState_q;
  logic [31:0] rdata_q;
  logic [2:0]  ctrl_q;
  logic [15:0] detect_q;
  logic [31:0] extPri_q;
  logic [7:0]  extLatch_q;
  logic [10:0] mask_q;
  logic [14:0] perPri_q;
  logic        nmiPrev_q;
  logic [7:0]  pinPrev_q;
  logic [2:0]  supCnt_q;
  logic        nmiPend_q;
  logic        req_q;
  logic [3:0]  level_q;
  logic [11:0] code_q;
  logic        isNmi_q;

  // bus handshake: one wait cycle, write lands when waitrequest is low
  wire busReq  = avs_read | avs_write;
  wire inAns   = (busState_q == pic_pkg::PIC_BUS_ANS);
  wire wrEn    = avs_write & inAns;
  wire [31:0] beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] wd     = avs_writedata & beMask;
  assign avs_waitrequest = busReq & ~inAns;
  assign avs_readdata    = rdata_q;

  // address decode
  wire selCtrl  = (avs_address == `PIC_CTRL_ADDR);
  wire selDet   = (avs_address == `PIC_DETECT_ADDR);
  wire selPri   = (avs_address == `PIC_EXTPRI_ADDR);
  wire selReq   = (avs_address == `PIC_EXTREQ_ADDR);
  wire selMask  = (avs_address == `PIC_MASK_ADDR);
  wire selPer   = (avs_address == `PIC_PERPRI_ADDR);
  wire selTbus  = (avs_address == `PIC_TBUS_STAT_ADDR);
  wire selMod   = (avs_address == `PIC_MOD_STAT_ADDR);

  // read mux, unmapped reads return zero
  wire [31:0] rdMux =
      selCtrl ? {27'h0, nmiPin, nmiPend_q, ctrl_q} :
      selDet  ? {16'h0, detect_q} :
      selPri  ? extPri_q :
      selReq  ? {24'h0, extLatch_q} :
      selMask ? {21'h0, mask_q} :
      selPer  ? {11'h0, perPri_q[14:10], 3'h0, perPri_q[9:5], 3'h0, perPri_q[4:0]} :
      selTbus ? {30'h0, perReq[2:1]} :
      selMod  ? {31'h0, perReq[0]} :
                32'h00000000;

  // merged write values honour byte enables
  wire [2:0]  ctrlNew = (ctrl_q & ~beMask[2:0]) | wd[2:0];
  wire [15:0] detNew  = (detect_q & ~beMask[15:0]) | wd[15:0];
  wire [31:0] priNew  = (extPri_q & ~beMask) | wd;
  wire [10:0] maskNew = (mask_q & ~beMask[10:0]) | wd[10:0];
  wire [14:0] perNew  = {(perPri_q[14:10] & ~beMask[20:16]) | wd[20:16],
                         (perPri_q[9:5] & ~beMask[12:8]) | wd[12:8],
                         (perPri_q[4:0] & ~beMask[4:0]) | wd[4:0]};
  wire edgeChg = wrEn & selCtrl & (ctrlNew[`PIC_CTRL_EDGE_BIT] != ctrl_q[`PIC_CTRL_EDGE_BIT]);
  wire [7:0] reqClr = (wrEn & selReq) ? wd[7:0] : 8'h00;

  // bus state and read capture
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      busState_q <= pic_pkg::PIC_BUS_IDLE;
      rdata_q    <= 32'h00000000;
    end else if (inAns) begin
      busState_q <= pic_pkg::PIC_BUS_IDLE;
    end else if (busReq) begin
      busState_q <= pic_pkg::PIC_BUS_ANS;
      rdata_q    <= avs_read ? rdMux : 32'h00000000;
    end
  end

  // software registers; reset leaves every source but the nmi masked
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q   <= 3'h0;
      detect_q <= 16'h0000;
      extPri_q <= 32'h00000000;
      mask_q   <= `PIC_MASK_RST;
      perPri_q <= 15'h0000;
    end else if (wrEn) begin
      if (selCtrl) ctrl_q <= ctrlNew;
      if (selDet)  detect_q <= detNew;
      if (selPri)  extPri_q <= priNew;
      if (selMask) mask_q <= maskNew;
      if (selPer)  perPri_q <= perNew;
    end
  end

  // nmi edge detection with a guard window after edge-select changes
  wire nmiRise = nmiPin & ~nmiPrev_q;
  wire nmiFall = ~nmiPin & nmiPrev_q;
  wire nmiHit  = (ctrl_q[`PIC_CTRL_EDGE_BIT] ? nmiRise : nmiFall) & (supCnt_q == 3'h0) & ~edgeChg;
  wire nmiAck  = core.intAck & isNmi_q;
  wire nmiLive = nmiPend_q & ~nmiAck;

  // pending nmi: a new edge in the ack cycle is kept
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      nmiPrev_q <= 1'b0;
      supCnt_q  <= 3'h0;
      nmiPend_q <= 1'b0;
    end else begin
      nmiPrev_q <= nmiPin;
      if (edgeChg) supCnt_q <= `PIC_NMI_SUPPRESS_CYC;
      else if (supCnt_q != 3'h0) supCnt_q <= supCnt_q - 3'h1;
      nmiPend_q <= nmiHit | (nmiPend_q & ~nmiAck);
    end
  end

  // per-pin detection and latching; set beats software clear
  logic [7:0] pinHit;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gPin
      wire [1:0] mode = detect_q[2*g+1:2*g];
      assign pinHit[g] = (mode == `PIC_DET_FALL) ? (~irqPin[g] & pinPrev_q[g]) :
                         (mode == `PIC_DET_RISE) ? (irqPin[g] & ~pinPrev_q[g]) :
                         (mode == `PIC_DET_LOW)  ? ~irqPin[g] :
                                                   irqPin[g];
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinPrev_q  <= 8'h00;
      extLatch_q <= 8'h00;
    end else begin
      pinPrev_q  <= irqPin;
      extLatch_q <= pinHit | (extLatch_q & ~reqClr);
    end
  end

  // candidate keys: five-bit compare, pins sit at odd keys of their level
  logic [NSRC-1:0] candOk;
  logic [4:0]      candKey [NSRC];
  generate
    for (g = 0; g < NSRC; g++) begin : gCand
      if (g < 8) begin : gExt
        wire [3:0] lvl = extPri_q[4*g+3:4*g];
        assign candKey[g] = {lvl, 1'b1};
        assign candOk[g]  = extLatch_q[g] & ~mask_q[g] & (lvl != 4'h0);
      end else begin : gPer
        assign candKey[g] = perPri_q[5*(g-8)+4:5*(g-8)];
        assign candOk[g]  = perReq[g-8] & ~mask_q[g] & (candKey[g] >= `PIC_PER_MIN_PRI);
      end
    end
  endgenerate

  // winner search; lower index wins ties as the fixed order
  logic       found;
  logic [4:0] bestKey;
  logic [3:0] bestIdx;
  always_comb begin
    found   = 1'b0;
    bestKey = 5'h00;
    bestIdx = 4'h0;
    for (int k = NSRC - 1; k >= 0; k--) begin
      if (candOk[k] && (!found || candKey[k] >= bestKey)) begin
        found   = 1'b1;
        bestKey = candKey[k];
        bestIdx = 4'(k);
      end
    end
  end

  // unique code per source
  wire [11:0] genCode = (bestIdx < 4'h8) ? IRQ_CODE0 + 12'(bestIdx) * `PIC_CODE_STEP
                                         : PER_CODE0 + 12'(bestIdx - 4'h8) * `PIC_CODE_STEP;
  // mask-all: only an edge-born nmi gets through while the pin is low
  wire blockAll = ctrl_q[`PIC_CTRL_MAI_BIT] & ~nmiPin;

  // presented request, rebuilt every cycle from the live state
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_q   <= 1'b0;
      level_q <= 4'h0;
      code_q  <= 12'h000;
      isNmi_q <= 1'b0;
    end else if (nmiLive) begin
      req_q   <= 1'b1;
      level_q <= `PIC_NMI_LEVEL;
      code_q  <= NMI_CODE;
      isNmi_q <= 1'b1;
    end else begin
      req_q   <= found & ~blockAll;
      level_q <= (found & ~blockAll) ? bestKey[4:1] : 4'h0;
      code_q  <= genCode;
      isNmi_q <= 1'b0;
    end
  end

  assign core.ext_request_latch         = req_q;
  assign core.intLevel       = level_q;
  assign core.intCode        = code_q;
  assign core.intIsNmi       = isNmi_q;
  assign core.intNmiOverride = ctrl_q[`PIC_CTRL_OVR_BIT];
endmodule : pic_controller
`default_nettype wire

//--- pic_cfg.svh
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH
// register byte addresses
`define PIC_CTRL_ADDR       32'hfffff400
`define PIC_DETECT_ADDR     32'hfffff404
`define PIC_EXTPRI_ADDR     32'hfffff408
`define PIC_EXTREQ_ADDR     32'hfffff40c
`define PIC_MASK_ADDR       32'hfffff410
`define PIC_PERPRI_ADDR     32'hfffff414
`define PIC_TBUS_STAT_ADDR  32'hfffff46c
`define PIC_MOD_STAT_ADDR   32'hfffff494
// control register fields
`define PIC_CTRL_EDGE_BIT   0
`define PIC_CTRL_OVR_BIT    1
`define PIC_CTRL_MAI_BIT    2
`define PIC_CTRL_PEND_BIT   3
`define PIC_CTRL_PIN_BIT    4
// reset values
`define PIC_MASK_RST        11'h7ff
// detection modes per external pin
`define PIC_DET_FALL        2'h0
`define PIC_DET_RISE        2'h1
`define PIC_DET_LOW         2'h2
`define PIC_DET_HIGH        2'h3
// timing and levels
`define PIC_NMI_SUPPRESS_CYC 3'h6
`define PIC_NMI_LEVEL        4'hf
`define PIC_PER_MIN_PRI      5'h02
`define PIC_HANDLER_OFFSET   32'h00000600
`define PIC_CODE_STEP        12'h020
`endif

//--- pic_pkg.sv
package pic_pkg;
  typedef enum logic [1:0] {
    PIC_BUS_IDLE = 2'b01,
    PIC_BUS_ANS  = 2'b10
  } pic_bus_e;
  typedef logic [11:0] pic_code_t;
  typedef logic [3:0]  pic_level_t;
endpackage : pic_pkg

//--- pic_core_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pic_core_if;
  logic                ext_request_latch;
  pic_pkg::pic_level_t intLevel;
  pic_pkg::pic_code_t  intCode;
  logic                intIsNmi;
  logic                intNmiOverride;
  logic                intAck;
  modport ctrl (output ext_request_latch, intLevel, intCode, intIsNmi, intNmiOverride, input intAck);
  modport core (input ext_request_latch, intLevel, intCode, intIsNmi, intNmiOverride, output intAck);
endinterface : pic_core_if
`default_nettype wire

//--- pic_core_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "pic_cfg.svh"
module pic_core_end (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  // link to the controller
  pic_core_if.core          link,
  // core pipeline side
  input  wire logic         instrBoundary,
  input  wire logic         autoMaskUpdate,
  input  wire logic [31:0]  vectorBase,
  input  wire logic         blockSet,
  input  wire logic         blockClr,
  input  wire logic         maskWr,
  input  wire logic [3:0]   maskData,
  // results
  output logic              acceptStrobe,
  output logic [31:0]       handlerAddr,
  output logic [11:0]       eventCode,
  output logic              tookNmi,
  output logic              blockBit,
  output logic [3:0]        levelMask
);
  logic        block_q;
  logic [3:0]  mask_q;
  logic [31:0] handler_q;
  logic [11:0] event_q;
  logic        nmi_q;

  // general request needs boundary, clear block and level above mask
  wire genOk = link.ext_request_latch & ~link.intIsNmi & ~block_q & instrBoundary
             & (link.intLevel > mask_q);
  // override lets nmi through at once, otherwise it waits for block clear and a boundary
  wire nmiOk = link.ext_request_latch & link.intIsNmi
             & (link.intNmiOverride | (~block_q & instrBoundary));
  wire accept = genOk | nmiOk;

  assign link.intAck   = accept;
  assign acceptStrobe  = accept;
  assign handlerAddr   = handler_q;
  assign eventCode     = event_q;
  assign tookNmi       = nmi_q;
  assign blockBit      = block_q;
  assign levelMask     = mask_q;

  // acceptance outranks a software block clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      block_q   <= 1'b1;
      mask_q    <= 4'hf;
      handler_q <= 32'h00000000;
      event_q   <= 12'h000;
      nmi_q     <= 1'b0;
    end else begin
      if (accept) begin
        block_q   <= 1'b1;
        event_q   <= link.intCode;
        handler_q <= vectorBase + `PIC_HANDLER_OFFSET;
        nmi_q     <= link.intIsNmi;
      end else if (blockSet) begin
        block_q <= 1'b1;
      end else if (blockClr) begin
        block_q <= 1'b0;
      end
      if (accept && autoMaskUpdate) begin
        mask_q <= link.intLevel;
      end else if (maskWr) begin
        mask_q <= maskData;
      end
    end
  end
endmodule : pic_core_end
`default_nettype wire

//--- pic_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pic_link_sva #(
  parameter logic [11:0] NMI_CODE = 12'h1c0
) (
  // clock and reset
  input wire logic                core_clk,
  input wire logic                rst_b,
  // controller to core link
  input wire logic                ext_request_latch,
  input wire pic_pkg::pic_level_t intLevel,
  input wire pic_pkg::pic_code_t  intCode,
  input wire logic                intIsNmi,
  input wire logic                intNmiOverride,
  input wire logic                intAck
);
  // one domain, so clock and reset are stated once
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // the core only answers what is on offer
  ack_needs_req_a: assert property (intAck |-> ext_request_latch)
    else $error("ack without a request");
  nmi_top_level_a: assert property (ext_request_latch && intIsNmi |-> intLevel == 4'hf)
    else $error("nmi not at top level");
  nmi_code_a: assert property (ext_request_latch && intIsNmi |-> intCode == NMI_CODE)
    else $error("nmi code wrong");
  code_unique_a: assert property (ext_request_latch && intCode == NMI_CODE |-> intIsNmi)
    else $error("nmi code on a general request");
  // level 0 means masked, so it is never offered
  zero_level_a: assert property (ext_request_latch && !intIsNmi |-> intLevel != 4'h0)
    else $error("level zero offered");
  gen_code_a: assert property (ext_request_latch && !intIsNmi |->
    intCode[4:0] == 5'h00 && intCode[11:8] inside {4'h2, 4'h4}) else $error("general code outside map");
  // a taken nmi must not come back without a new edge
  nmi_once_a: assert property (intAck && intIsNmi |=> !(ext_request_latch && intIsNmi))
    else $error("nmi offered again after ack");
  // reset is async, so this one looks inside reset itself
  reset_quiet_a: assert property (disable iff (1'b0) !rst_b |->
    !ext_request_latch && !intIsNmi && intLevel == 4'h0 && intCode == 12'h000) else $error("link busy in reset");
  nmi_taken_c: cover property (intAck && intIsNmi);
  gen_taken_c: cover property (intAck && !intIsNmi);
  override_c: cover property (ext_request_latch && intNmiOverride);
endmodule : pic_link_sva
`default_nettype wire

//--- priority_interrupt_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pic_cfg.svh"
module priority_interrupt_controller_tb;
  localparam logic [11:0] NmiCode = 12'h1c0;
  // bench drives, all set at time zero
  logic        core_clk = 1'b0;
  logic        rst_b    = 1'b1;
  logic        ib       = 1'b1;
  logic        rdReq    = 1'b0;
  logic        wrReq    = 1'b0;
  logic [31:0] addr     = 32'h0;
  logic [31:0] wdata    = 32'h0;
  logic        nmi      = 1'b0;
  logic [7:0]  irq      = 8'h00;
  logic [2:0]  per      = 3'h0;
  logic        amu      = 1'b1;
  logic [31:0] vb       = 32'h0;
  logic        bc       = 1'b0;
  logic        mw       = 1'b0;
  logic [3:0]  md       = 4'h0;
  logic [31:0] seed     = 32'h0000c642; // 50754
  // design outputs
  logic [31:0] rdata;
  logic [31:0] hnd;
  logic        waitReq;
  logic        took;
  logic [11:0] evt;
  logic [3:0]  lmask;
  int          nMismatch = 0;
  int          numChecks = 0;
  pic_core_if link ();
  wire logic [31:0] linkV = {14'h0, link.intIsNmi, link.ext_request_latch, link.intLevel, link.intCode};
  pic_controller #(.NMI_CODE(NmiCode)) u_pic_controller (.core_clk(core_clk), .rst_b(rst_b),
    .avs_address(addr), .avs_read(rdReq), .avs_write(wrReq), .avs_writedata(wdata),
    .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(waitReq),
    .nmiPin(nmi), .irqPin(irq), .perReq(per), .core(link));
  pic_core_end u_pic_core_end (.core_clk(core_clk), .rst_b(rst_b), .link(link), .instrBoundary(ib),
    .autoMaskUpdate(amu), .vectorBase(vb), .blockSet(1'b0), .blockClr(bc), .maskWr(mw), .maskData(md),
    .acceptStrobe(), .handlerAddr(hnd), .eventCode(evt), .tookNmi(took), .blockBit(), .levelMask(lmask));
  pic_link_sva #(.NMI_CODE(NmiCode)) u_pic_link_sva (.core_clk(core_clk), .rst_b(rst_b),
    .ext_request_latch(link.ext_request_latch), .intLevel(link.intLevel), .intCode(link.intCode), .intIsNmi(link.intIsNmi),
    .intNmiOverride(link.intNmiOverride), .intAck(link.intAck));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // request held until waitrequest is seen low, then released
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    i = 0;
    addr <= a;
    wdata <= d;
    wrReq <= w;
    rdReq <= !w;
    do begin
      @(posedge core_clk);
      i++;
    end while (waitReq !== 1'b0 && i < 40);
    q = rdata;
    wrReq <= 1'b0;
    rdReq <= 1'b0;
    if (i >= 40) begin
      nMismatch++;
      report_and_stop();
    end
    @(posedge core_clk); // idle gap, strobes never toggle twice in one step
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(nm, exp, x);
  endtask : rdc
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // expected peripheral winner, packed like linkV; p[30:28] are the requests
  function automatic logic [31:0] perExp(input logic [31:0] p);
    logic [4:0]  best;
    logic [11:0] code;
    best = 5'h01;
    code = 12'h000;
    for (int j = 0; j < 3; j++) begin
      if (p[28 + j] && p[8 * j +: 5] > best) begin
        best = p[8 * j +: 5];
        code = 12'h400 + 12'h020 * j[11:0];
      end
    end
    return (best > 5'h01) ? {15'h0, 1'b1, best[4:1], code} : 32'h0;
  endfunction : perExp
  initial begin
    logic [31:0] p;
    logic        idle;
    rst_b <= 1'b0; // a real falling edge, so every flop is in reset before the first clock
    tick(20);
    rst_b <= 1'b1;
    vb <= rnd();
    tick(1);
    rdc("mask", `PIC_MASK_ADDR, 32'h7ff);
    rdc("unmapped", 32'hfffff4f0, 32'h0);
    per <= 3'h7;
    wr(`PIC_MOD_STAT_ADDR, 32'hffffffff);
    rdc("mod stat", `PIC_MOD_STAT_ADDR, 32'h1);
    rdc("bus stat", `PIC_TBUS_STAT_ADDR, 32'h3);
    wr(`PIC_MASK_ADDR, 32'h0ff);
    // random priorities, first two are a tie and an all-masked case
    for (int k = 0; k < 12; k++) begin
      p = rnd();
      if (k == 0) p = 32'h701b1b1a;
      if (k == 1) p = 32'h70010001;
      per <= p[30:28];
      wr(`PIC_PERPRI_ADDR, p & 32'h001f1f1f);
      tick(2);
      chk("link", perExp(p), linkV & {16'h1, {16{link.ext_request_latch}}});
      rdc("mod stat", `PIC_MOD_STAT_ADDR, {31'h0, p[28]});
    end
    // each detection mode on pin 0, latch must outlive the pulse
    for (int m = 0; m < 4; m++) begin
      idle = (m == 0 || m == 2);
      irq <= {7'h0, idle};
      wr(`PIC_DETECT_ADDR, {16'h0, 14'h1555, m[1:0]});
      tick(3);
      wr(`PIC_EXTREQ_ADDR, 32'hff);
      rdc("latch clr", `PIC_EXTREQ_ADDR, 32'h0);
      irq <= {7'h0, !idle};
      tick(2);
      irq <= {7'h0, idle};
      tick(4);
      rdc("latch held", `PIC_EXTREQ_ADDR, 32'h1);
    end
    wr(`PIC_EXTPRI_ADDR, 32'h5);
    wr(`PIC_MASK_ADDR, 32'h7fe);
    tick(2);
    chk("pin link", 32'h00015200, linkV);
    bc <= 1'b1;
    tick(1);
    bc <= 1'b0;
    tick(3);
    chk("refused", 32'h0, {20'h0, evt});
    // level now above mask, but no instruction boundary yet
    ib <= 1'b0;
    mw <= 1'b1;
    md <= 4'h4;
    tick(1);
    mw <= 1'b0;
    tick(3);
    chk("no boundary", 32'h0, {20'h0, evt});
    ib <= 1'b1;
    tick(3);
    chk("handler", vb + 32'h600, hnd);
    chk("event", 32'h200, {20'h0, evt});
    chk("auto mask", 32'h5, {28'h0, lmask});
    amu <= 1'b0;
    mw <= 1'b1;
    md <= 4'h0;
    bc <= 1'b1;
    tick(1);
    mw <= 1'b0;
    bc <= 1'b0;
    tick(3);
    chk("kept mask", 32'h0, {28'h0, lmask});
    wr(`PIC_EXTREQ_ADDR, 32'hff);
    wr(`PIC_CTRL_ADDR, 32'h1);
    tick(8);
    nmi <= 1'b1;
    tick(6);
    chk("nmi blocked", 32'h0, {31'h0, took});
    rdc("nmi pend", `PIC_CTRL_ADDR, 32'h19);
    wr(`PIC_CTRL_ADDR, 32'h3);
    tick(3);
    chk("nmi taken", {20'h0, NmiCode}, {20'h0, evt});
    nmi <= 1'b0;
    tick(6);
    rdc("fall ignored", `PIC_CTRL_ADDR, 32'h3);
    per <= 3'h1;
    wr(`PIC_PERPRI_ADDR, 32'h1f);
    wr(`PIC_MASK_ADDR, 32'h6ff);
    // take the top peripheral first, so the later nmi has to replace its code
    bc <= 1'b1;
    tick(1);
    bc <= 1'b0;
    tick(2);
    chk("per taken", 32'h400, {20'h0, evt});
    wr(`PIC_CTRL_ADDR, 32'h7);
    tick(3);
    chk("mask all", 32'h0, {31'h0, link.ext_request_latch});
    nmi <= 1'b1;
    tick(6);
    chk("nmi wins", {20'h0, NmiCode}, {20'h0, evt});
    chk("pin high", 32'h0001f400, linkV);
    report_and_stop();
  end
endmodule : priority_interrupt_controller_tb
`default_nettype wire
